// ---- rtl/io_port_bank.sv ----
// Two six-bit I/O ports with direction logic; pull-up and wake-on-change logic on the first port only.
`timescale 1ns/1ps
module six_bit_io_port_bank
  import io_port_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cycle_start,
  input  wire logic        i_cycle_end,
  input  wire port_op_type i_op,
  input  wire logic [4:0]  i_addr,
  input  wire logic [2:0]  i_bit,
  input  wire logic [7:0]  i_wreg,
  input  wire logic        i_wake_reset,
  input  wire logic        i_sleeping,
  input  wire logic        i_master_clear_input_enable,
  input  wire logic [5:0]  i_first_alt_mask,
  input  wire logic [5:0]  i_second_alt_mask,
  input  wire logic [5:0]  i_first_pin_in,
  input  wire logic [5:0]  i_second_pin_in,
  output logic [5:0]       o_first_pin_out,
  output logic [5:0]       o_first_pin_oe,
  output logic [5:0]       o_second_pin_out,
  output logic [5:0]       o_second_pin_oe,
  output logic [5:0]       o_first_pullup_en,
  output logic [7:0]       o_rdata,
  output logic             o_pin_change_wake_flag,
  output logic             o_wake_request
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] first_s1, first_s2, first_s3, first_pins;
  logic [5:0] second_s1, second_s2, second_s3, second_pins;

  always_ff @(posedge i_core_clk) begin
    first_s1  <= i_first_pin_in;
    first_s2  <= first_s1;
    first_s3  <= first_s2;
    second_s1 <= i_second_pin_in;
    second_s2 <= second_s1;
    second_s3 <= second_s2;
  end

  // A level counts only once two stages agree, so a glitch is not read.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      first_pins  <= 6'h00;
      second_pins <= 6'h00;
    end else begin
      for (int i = 0; i < PORT_WIDTH; i++) begin
        if (first_s2[i] == first_s3[i]) begin
          first_pins[i] <= first_s3[i];
        end
        if (second_s2[i] == second_s3[i]) begin
          second_pins[i] <= second_s3[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [5:0] dir_first;
  logic [5:0] dir_second;
  logic [7:0] option;
  logic [5:0] latch_first;
  logic [5:0] latch_second;
  logic [5:0] snap_first;
  logic [5:0] snap_second;
  logic       op_pending;
  logic       op_is_second;

  wire sel_first  = (i_addr == FIRST_PORT_ADDR);
  wire sel_second = (i_addr == SECOND_PORT_ADDR);
  wire sel_any    = sel_first | sel_second;

  // Pins read as zero where an alternate function owns them.
  wire [5:0] read_first  = first_pins & ~i_first_alt_mask;
  wire tmr_owns          = option[TMR_CLK_SEL_BIT];
  wire [5:0] second_alt  = i_second_alt_mask | {tmr_owns, 5'h00};
  wire [5:0] read_second = second_pins & ~second_alt;

  // Bit operations work on the value sampled at the start of the cycle.
  wire [5:0] snap_sel  = op_is_second ? snap_second : snap_first;
  wire [5:0] bit_mask  = 6'h01 << i_bit;
  wire       bit_valid = (i_bit < 3'd6);
  wire [5:0] rmw_set   = bit_valid ? (snap_sel | bit_mask) : snap_sel;
  wire [5:0] rmw_clr   = bit_valid ? (snap_sel & ~bit_mask) : snap_sel;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      snap_first   <= 6'h00;
      snap_second  <= 6'h00;
      op_pending   <= 1'b0;
      op_is_second <= 1'b0;
    end else if (i_cycle_start) begin
      snap_first   <= read_first;
      snap_second  <= read_second;
      op_pending   <= (i_op != OP_NONE);
      op_is_second <= sel_second;
    end else if (i_cycle_end) begin
      op_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dir_first  <= DIR_RESET;
      dir_second <= DIR_RESET;
      option     <= OPTION_RESET;
    end else if (i_cycle_end && op_pending) begin
      if (i_op == OP_DIR_LOAD && sel_first) begin
        dir_first <= i_wreg[5:0];
      end
      if (i_op == OP_DIR_LOAD && sel_second) begin
        dir_second <= i_wreg[5:0];
      end
      if (i_op == OP_OPT_LOAD) begin
        option <= i_wreg;
      end
    end
  end

  // Latches are not reset: their content is unknown until first written.
  always_ff @(posedge i_core_clk) begin
    if (i_cycle_end && op_pending && sel_any) begin
      unique case (i_op)
        OP_WRITE: begin
          if (sel_first) latch_first <= i_wreg[5:0];
          else latch_second <= i_wreg[5:0];
        end
        OP_BIT_SET: begin
          if (sel_first) latch_first <= rmw_set;
          else latch_second <= rmw_set;
        end
        OP_BIT_CLR: begin
          if (sel_first) latch_first <= rmw_clr;
          else latch_second <= rmw_clr;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [5:0] drive_first_mask;
  logic [5:0] drive_second_mask;
  assign drive_first_mask  = ~dir_first & ~(6'h01 << MASTER_CLEAR_INPUT_PIN);
  assign drive_second_mask = ~dir_second & ~{tmr_owns, 5'h00};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_first_pin_out  <= 6'h00;
      o_first_pin_oe   <= 6'h00;
      o_second_pin_out <= 6'h00;
      o_second_pin_oe  <= 6'h00;
    end else begin
      o_first_pin_out  <= latch_first & drive_first_mask;
      o_first_pin_oe   <= drive_first_mask;
      o_second_pin_out <= latch_second & drive_second_mask;
      o_second_pin_oe  <= drive_second_mask;
    end
  end

  // ----------------------------------------
  // Pull-ups and wake-on-change
  // ----------------------------------------
  wire       pullup_on  = ~option[PULLUP_DIS_BIT];
  wire       wake_on    = ~option[WAKE_DIS_BIT];
  wire [5:0] master_clear_input_bit   = i_master_clear_input_enable ? (6'h01 << MASTER_CLEAR_INPUT_PIN) : 6'h00;
  wire [5:0] pu_mask    = (pullup_on ? SHARED_PIN_MASK : 6'h00) | master_clear_input_bit;
  wire [5:0] wake_mask  = wake_on ? (SHARED_PIN_MASK & ~master_clear_input_bit) : 6'h00;
  wire       mismatch   = |((first_pins ^ snap_first) & wake_mask);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_first_pullup_en      <= 6'h00;
      o_wake_request         <= 1'b0;
    end else begin
      o_first_pullup_en <= pu_mask;
      o_wake_request    <= i_sleeping & mismatch;
    end
  end

  // The wake flag records the cause of the reset that is now being taken.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pin_change_wake_flag <= i_wake_reset ? 1'b1 : 1'b0;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [7:0] status_rd = {o_pin_change_wake_flag, 7'h00};
  wire [7:0] port_rd   = {2'b00, sel_first ? read_first : read_second};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_cycle_start && i_op == OP_READ) begin
      if (sel_any) begin
        o_rdata <= port_rd;
      end else if (i_addr == STATUS_ADDR) begin
        o_rdata <= status_rd;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

// ---- rtl/io_port_pkg.sv ----
// Constants and types shared by the six-bit I/O port bank.
// Behaviour
// - Port reads return pin levels, not latches.
// - Only bits 5..0 exist; bits 7,6 read zero.
// - Pin 3 of the first port is input only, never driven.
// - Alternate-function pins read as zero.
// - One shared pull-up and wake enable.
// - Master clear: pull-up on, no wake on pin 3.
// - Direction load copies working value to direction.
// - Direction one floats pin, zero drives latch.
// - Direction registers write-only, reset to ones.
// - Timer clock owns port C pin 5 after reset.
// - Latches hold; inputs are not latched.
// - Bit set/clear rewrites all latches of the addressed port from pins.
// - Write at cycle end, read at cycle start.
// - Wake flag set on pin-change wake reset only.
// - Option bit 7 zero enables wake-on-change.
// - Option bit 6 zero enables weak pull-ups.
// - Timer clock select forces its pin to input.
package io_port_pkg;

  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [4:0] STATUS_ADDR      = 5'h03;
  localparam logic [4:0] FIRST_PORT_ADDR  = 5'h06;
  localparam logic [4:0] SECOND_PORT_ADDR = 5'h07;
  localparam int         WAKE_FLAG_BIT    = 7;
  localparam int         WAKE_DIS_BIT     = 7;
  localparam int         PULLUP_DIS_BIT   = 6;
  localparam int         TMR_CLK_SEL_BIT  = 5;
  localparam int         PORT_WIDTH       = 6;
  localparam int         MASTER_CLEAR_INPUT_PIN         = 3;
  localparam int         TMR_CLK_PIN      = 5;
  localparam logic [5:0] DIR_RESET        = 6'h3f;
  localparam logic [7:0] OPTION_RESET     = 8'hff;
  localparam logic [5:0] SHARED_PIN_MASK  = 6'h1b;

  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_READ     = 3'b001,
    OP_WRITE    = 3'b010,
    OP_BIT_SET  = 3'b011,
    OP_BIT_CLR  = 3'b100,
    OP_DIR_LOAD = 3'b101,
    OP_OPT_LOAD = 3'b110
  } port_op_type;

endpackage

// ---- dv/io_port_sva.sv ----
// Concurrent checks on the port bank outputs.
`timescale 1ns/1ps
module io_port_sva
  import io_port_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_cycle_start,
  input wire port_op_type i_op,
  input wire logic [4:0]  i_addr,
  input wire logic        i_wake_reset,
  input wire logic        i_master_clear_input_enable,
  input wire logic [5:0]  i_first_alt_mask,
  input wire logic [5:0]  i_first_pin_in,
  input wire logic [5:0]  o_first_pin_oe,
  input wire logic [5:0]  o_first_pullup_en,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_pin_change_wake_flag
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire rd = i_cycle_start && i_op == OP_READ && i_addr == FIRST_PORT_ADDR;
  // Pins pass a synchroniser, so only reads of settled pins are judged.
  pins_read_a: assert property ($stable(i_first_pin_in) [*5] ##0 rd |=>
    o_rdata[5:0] == ($past(i_first_pin_in) & ~$past(i_first_alt_mask))) else $error("bad read");
  high_bits_a: assert property (rd |=> o_rdata[7:6] == 2'b00) else $error("high bits");
  alt_zero_a: assert property (rd |=> (o_rdata[5:0] & $past(i_first_alt_mask)) == 6'h00)
    else $error("alt pin read");
  pin3_input_a: assert property (!o_first_pin_oe[MASTER_CLEAR_INPUT_PIN]) else $error("pin 3 driven");
  pullup_shared_a: assert property ((o_first_pullup_en & ~SHARED_PIN_MASK) == 6'h00)
    else $error("stray pull-up");
  master_clear_input_pullup_a: assert property (i_master_clear_input_enable [*2] |=> o_first_pullup_en[MASTER_CLEAR_INPUT_PIN])
    else $error("reset pin pull-up off");
  dir_reset_a: assert property (disable iff (1'b0) i_rst |=> o_first_pin_oe == 6'h00)
    else $error("driver on after reset");
  wake_flag_a: assert property (disable iff (1'b0) i_rst |=>
    o_pin_change_wake_flag == $past(i_wake_reset)) else $error("wake flag wrong");
  cover property (rd);
  cover property (i_master_clear_input_enable && o_first_pullup_en[MASTER_CLEAR_INPUT_PIN]);
  cover property (o_first_pin_oe != 6'h00);
endmodule
bind six_bit_io_port_bank io_port_sva chk (.*);

// ---- dv/pin_board.sv ----
// Board model of one port: outside sources only pull high, plus weak pull-ups.
`timescale 1ns/1ps
module pin_board (
  input  wire logic [5:0] i_out,
  input  wire logic [5:0] i_oe,
  input  wire logic [5:0] i_pu,
  input  wire logic [5:0] i_ext,
  output logic [5:0]      o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & (i_pu | i_ext));
endmodule

// ---- dv/six_bit_io_port_bank_bench.sv ----
// Self-checking bench for the six-bit port bank.
`timescale 1ns/1ps
module six_bit_io_port_bank_bench;
  import io_port_pkg::*;
  logic        i_core_clk = 0, i_rst = 1, i_cycle_start = 0, i_cycle_end = 0, i_sleeping = 0;
  logic        i_wake_reset = 1, i_master_clear_input_enable = 0, o_pin_change_wake_flag, o_wake_request;
  port_op_type i_op = OP_NONE;
  logic [4:0]  i_addr = 5'h00;
  logic [2:0]  i_bit = 3'h0;
  logic [7:0]  i_wreg = 8'h00, o_rdata, opt = 8'hff, exp_q[$];
  logic [5:0]  i_first_alt_mask = 6'h00, i_second_alt_mask = 6'h00, i_first_pin_in;
  logic [5:0]  i_second_pin_in, o_first_pin_out, o_first_pin_oe, o_second_pin_out;
  logic [5:0]  o_second_pin_oe, o_first_pullup_en, x1 = 6'h00, x2 = 6'h00;
  logic [5:0]  d1 = 6'h3f, d2 = 6'h3f, l1, l2, v;
  logic [1:0]  seen = 2'b00;
  logic        wf = 1'b1;
  int          err_count = 0, num_checks = 0, k;

  six_bit_io_port_bank uut (.*);
  pin_board b1 (.i_out(o_first_pin_out), .i_oe(o_first_pin_oe), .i_pu(o_first_pullup_en),
                .i_ext(x1), .o_pin(i_first_pin_in));
  pin_board b2 (.i_out(o_second_pin_out), .i_oe(o_second_pin_oe), .i_pu(6'h00), .i_ext(x2),
                .o_pin(i_second_pin_in));
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) seen <= {seen[0], i_cycle_start && i_op == OP_READ};
  always @(negedge i_core_clk) if (seen[1]) chk(exp_q.pop_front(), o_rdata);

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_wake(input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected pin levels come from the bench's own copy of latches and directions.
  task automatic op(port_op_type o, logic [4:0] a, logic [2:0] b, logic [7:0] w);
    logic f;
    f = a == FIRST_PORT_ADDR;
    repeat (6) @(negedge i_core_clk);
    if (f) v = (~(d1 | 6'h08) & l1) | ((d1 | 6'h08) & (x1 | {2'b00, i_master_clear_input_enable, 3'b000}
               | (opt[6] ? 6'h00 : SHARED_PIN_MASK)));
    else v = ((~d2 & l2) | (d2 & x2)) & ~{opt[5], 5'h00};
    if (o == OP_READ) exp_q.push_back(a == STATUS_ADDR ? {wf, 7'h00} :
                                      {2'b00, v & ~(f ? i_first_alt_mask : 6'h00)});
    if (o == OP_BIT_SET || o == OP_BIT_CLR) v[b] = o == OP_BIT_SET;
    if (o == OP_WRITE) v = w[5:0];
    if (o inside {OP_WRITE, OP_BIT_SET, OP_BIT_CLR}) if (f) l1 = v; else l2 = v;
    if (o == OP_DIR_LOAD) if (f) d1 = w[5:0]; else d2 = w[5:0];
    if (o == OP_OPT_LOAD) opt = w;
    i_op = o;
    i_addr = a;
    i_bit = b;
    i_wreg = w;
    i_cycle_start = 1;
    @(negedge i_core_clk) i_cycle_start = 0;
    @(negedge i_core_clk) i_cycle_end = 1;
    @(negedge i_core_clk) i_cycle_end = 0;
    i_op = OP_NONE;
  endtask

  initial begin
    k = $urandom(32'hb656);
    repeat (16) @(negedge i_core_clk);
    i_rst = 0;
    i_wake_reset = 0;
    x1 = 6'($urandom);
    x2 = 6'($urandom);
    op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    op(OP_READ, SECOND_PORT_ADDR, 3'h0, 8'h00);
    for (k = 0; k < 18; k++) begin
      x1 = 6'($urandom);
      op(OP_DIR_LOAD, FIRST_PORT_ADDR, 3'h0, 8'($urandom));
      op(port_op_type'(3'(2 + k % 3)), FIRST_PORT_ADDR, 3'(k / 3), 8'($urandom));
      op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    end
    i_first_alt_mask = 6'($urandom);
    op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    i_first_alt_mask = 6'h00;
    op(OP_DIR_LOAD, SECOND_PORT_ADDR, 3'h0, 8'h00);
    op(OP_WRITE, SECOND_PORT_ADDR, 3'h0, 8'($urandom));
    op(OP_READ, SECOND_PORT_ADDR, 3'h0, 8'h00);
    i_master_clear_input_enable = 1;
    x1 = 6'h00;
    op(OP_DIR_LOAD, FIRST_PORT_ADDR, 3'h0, 8'hff);
    op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    op(OP_OPT_LOAD, 5'h00, 3'h0, 8'h9f);
    op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    op(OP_READ, SECOND_PORT_ADDR, 3'h0, 8'h00);
    op(OP_OPT_LOAD, 5'h00, 3'h0, 8'h5f);
    op(OP_READ, FIRST_PORT_ADDR, 3'h0, 8'h00);
    i_sleeping = 1;
    repeat (8) @(negedge i_core_clk);
    chk_wake(1'b0, o_wake_request);
    x1 = 6'h01;
    repeat (8) @(negedge i_core_clk);
    chk_wake(1'b1, o_wake_request);
    i_sleeping = 0;
    op(OP_READ, STATUS_ADDR, 3'h0, 8'h00);
    // A second reset, not caused by a pin change, must clear the wake flag.
    i_rst = 1;
    wf = 1'b0;
    repeat (16) @(negedge i_core_clk);
    i_rst = 0;
    d1 = 6'h3f;
    d2 = 6'h3f;
    opt = 8'hff;
    op(OP_READ, STATUS_ADDR, 3'h0, 8'h00);
    stop_test();
  end

  initial begin
    repeat (50000) @(posedge i_core_clk);
    err_count++;
    stop_test();
  end
endmodule
